// >>> hdl/pts_pkg.sv
package pts_pkg;
	// register byte offsets on the slave
	localparam logic [7:0] CTRL_OFF      = 8'h00;
	localparam logic [7:0] PERIOD_OFF    = 8'h04;
	localparam logic [7:0] COUNT_OFF     = 8'h08;
	localparam logic [7:0] IRQ_FLAG_OFF  = 8'h0c;
	localparam logic [7:0] IRQ_EN_OFF    = 8'h10;
	localparam logic [7:0] AUX_OFF       = 8'h14;
	// control field positions
	localparam int         POST_LSB      = 3;
	localparam int         RUN_BIT       = 2;
	localparam int         PRE_LSB       = 0;
	localparam logic [7:0] CTRL_MASK     = 8'h7f;
	// reset values
	localparam logic [7:0] CTRL_RST      = 8'h00;
	localparam logic [7:0] PERIOD_RST    = 8'hff;
	localparam logic [7:0] COUNT_RST     = 8'h00;
	// instruction clock is a quarter of the system clock
	localparam int         INSTR_DIV     = 4;
	localparam logic [1:0] INSTR_LAST    = 2'h3;
	// prescaler terminal counts per select code, minus one
	localparam logic [5:0] PRE_LAST_1    = 6'h00;
	localparam logic [5:0] PRE_LAST_4    = 6'h03;
	localparam logic [5:0] PRE_LAST_16   = 6'h0f;
	localparam logic [5:0] PRE_LAST_64   = 6'h3f;
	localparam logic [1:0] RESP_OKAY     = 2'h0;
	localparam logic [1:0] RESP_SLVERR   = 2'h2;
endpackage : pts_pkg

// >>> hdl/pts_postscale.sv
`timescale 1ns/1ps
// counts match pulses, fires once every sel+1 matches
module pts_postscale (
	input  wire logic       aclk,
	input  wire logic       aresetn,
	input  wire logic       match,
	input  wire logic       clear,
	input  wire logic [3:0] sel,
	output logic            fire
);
	typedef struct packed {
		logic [3:0] cnt;
	} pts_post_state_t;

	pts_post_state_t s_r;
	pts_post_state_t s_nxt;

	// advance only on the match pulse
	always_comb begin
		s_nxt = s_r;
		fire  = match && (s_r.cnt >= sel);
		if (clear) begin
			s_nxt.cnt = 4'h0;
		end else if (fire) begin
			s_nxt.cnt = 4'h0;
		end else if (match) begin
			s_nxt.cnt = s_r.cnt + 4'h1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end
endmodule : pts_postscale

// >>> hdl/pts_prescale.sv
`timescale 1ns/1ps
// divides instruction ticks by 1, 4, 16 or 64
module pts_prescale (
	input  wire logic       aclk,
	input  wire logic       aresetn,
	input  wire logic       tick,
	input  wire logic       clear,
	input  wire logic [1:0] sel,
	output logic            pulse
);
	typedef struct packed {
		logic [5:0] cnt;
	} pts_pre_state_t;

	pts_pre_state_t s_r;
	pts_pre_state_t s_nxt;
	logic [5:0]     last;

	// terminal count and next state
	always_comb begin
		s_nxt = s_r;
		unique case (sel)
			2'h0: last = pts_pkg::PRE_LAST_1;
			2'h1: last = pts_pkg::PRE_LAST_4;
			2'h2: last = pts_pkg::PRE_LAST_16;
			2'h3: last = pts_pkg::PRE_LAST_64;
		endcase
		pulse = tick && (s_r.cnt >= last);
		if (clear) begin
			s_nxt.cnt = 6'h00;
		end else if (pulse) begin
			s_nxt.cnt = 6'h00;
		end else if (tick) begin
			s_nxt.cnt = s_r.cnt + 6'h01;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end
endmodule : pts_prescale

// >>> hdl/pts_timer.sv
// The AXI4-Lite register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
// Functional notes
// RL1: every count-equals-period match advances a 4-bit postscaler, which sees nothing else.
// RL2: when the postscaler reaches its selected count the sticky match flag is set until cleared.
// RL3: the match flag reaches the interrupt output only while its enable bit is set.
// RL4: control bits 6..3 select the postscale, value n meaning one flag per n+1 matches.
// RL5: the unscaled match pulse is driven out as the pwm time base.
// RL6: the unscaled match pulse is also offered as the serial port shift clock source.
// RL7: while sleep is asserted nothing counts, matches or advances.
// RL8: count and period keep their values across sleep.
// RL9: control bit 2 runs the timer when set and halts it when clear.
// RL10: control bits 1..0 pick a prescale of 1, 4, 16 or 64.
// RL11: control bit 7 reads zero and ignores writes.
// RL12: the timer counts instruction clocks, a quarter of the system clock, after the prescaler.
// RL13: on count equal to period a match pulse fires and the count returns to zero next cycle.
// RL14: writes to count or control and every reset clear both prescaler and postscaler; a control write leaves the count alone.
// RL15: reset clears the count and sets the period to all ones.
// RL16: all control bits reset to zero, so the timer starts halted at unity scaling.
module pts_timer (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        sleep,
	input  wire logic [31:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [31:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic             irq,
	output logic             pwm_time_base,
	output logic             spi_shift_clk
);
	typedef struct packed {
		logic [7:0]  ctrl;
		logic [7:0]  period;
		logic [7:0]  count;
		logic        flag;
		logic        enable;
		logic        spi_sel;
		logic [1:0]  qdiv;
		logic        aw_got;
		logic        awready;
		logic [7:0]  aw_addr;
		logic        w_got;
		logic        wready;
		logic [31:0] w_data;
		logic [3:0]  w_strb;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
		logic        irq;
		logic        pwm;
		logic        spi;
	} pts_state_t;

	pts_state_t s_r;
	pts_state_t s_nxt;
	logic       instr_tick;
	logic       pre_pulse;
	logic       match;
	logic       post_fire;
	logic       scaler_clr;
	logic       wr_go;
	logic       wr_ok;
	logic [7:0] wb;

	// quarter-rate tick gated by run bit and sleep
	assign instr_tick = (s_r.qdiv == pts_pkg::INSTR_LAST) && s_r.ctrl[pts_pkg::RUN_BIT] && !sleep; // RL12 RL9 RL7
	// write takes both channels; response slot must be free
	assign wr_go      = s_r.aw_got && s_r.w_got && !s_r.bvalid;
	assign wr_ok      = wr_go && s_r.w_strb[0];
	assign wb         = s_r.w_data[7:0];
	// control or count write clears both scalers
	assign scaler_clr = wr_ok && (s_r.aw_addr == pts_pkg::CTRL_OFF || s_r.aw_addr == pts_pkg::COUNT_OFF); // RL14
	// comparator is sampled on the prescaled edge only
	assign match      = pre_pulse && (s_r.count == s_r.period); // RL13

	pts_prescale u_pre (
		.aclk    (aclk),
		.aresetn (aresetn),
		.tick    (instr_tick),
		.clear   (scaler_clr),
		.sel     (s_r.ctrl[pts_pkg::PRE_LSB +: 2]), // RL10
		.pulse   (pre_pulse)
	);

	pts_postscale u_post (
		.aclk    (aclk),
		.aresetn (aresetn),
		.match   (match), // RL1
		.clear   (scaler_clr), // RL14
		.sel     (s_r.ctrl[pts_pkg::POST_LSB +: 4]), // RL4
		.fire    (post_fire)
	);

	// next state for timer, registers and bus slave
	always_comb begin
		s_nxt = s_r;
		s_nxt.qdiv = sleep ? s_r.qdiv : s_r.qdiv + 2'h1; // RL7
		// counting; held untouched through sleep
		if (match) begin
			s_nxt.count = 8'h00; // RL13
		end else if (pre_pulse) begin
			s_nxt.count = s_r.count + 8'h01; // RL12
		end
		// capture bus channels
		if (s_axi_awvalid && !s_r.aw_got) begin
			s_nxt.aw_got  = 1'b1;
			s_nxt.aw_addr = s_axi_awaddr[7:0];
		end
		if (s_axi_wvalid && !s_r.w_got) begin
			s_nxt.w_got  = 1'b1;
			s_nxt.w_data = s_axi_wdata;
			s_nxt.w_strb = s_axi_wstrb;
		end
		// software write clear of the flag
		if (wr_ok && s_r.aw_addr == pts_pkg::IRQ_FLAG_OFF && wb[0]) begin
			s_nxt.flag = 1'b0;
		end
		if (post_fire) begin
			s_nxt.flag = 1'b1; // RL2
		end
		// register writes; count write beats the counter
		if (wr_go) begin
			s_nxt.aw_got = 1'b0;
			s_nxt.w_got  = 1'b0;
			s_nxt.bvalid = 1'b1;
			s_nxt.bresp  = pts_pkg::RESP_OKAY;
			unique case (s_r.aw_addr)
				pts_pkg::CTRL_OFF: begin
					if (wr_ok) s_nxt.ctrl = wb & pts_pkg::CTRL_MASK; // RL11
				end
				pts_pkg::PERIOD_OFF: begin
					if (wr_ok) s_nxt.period = wb;
				end
				pts_pkg::COUNT_OFF: begin
					if (wr_ok) s_nxt.count = wb;
				end
				pts_pkg::IRQ_FLAG_OFF: begin
				end
				pts_pkg::IRQ_EN_OFF: begin
					if (wr_ok) s_nxt.enable = wb[0];
				end
				pts_pkg::AUX_OFF: begin
					if (wr_ok) s_nxt.spi_sel = wb[0];
				end
				default: begin
					s_nxt.bresp = pts_pkg::RESP_SLVERR;
				end
			endcase
		end
		if (s_r.bvalid && s_axi_bready) begin
			s_nxt.bvalid = 1'b0;
		end
		// read: accept address, answer next cycle
		s_nxt.arready = 1'b0;
		if (s_axi_arvalid && !s_r.arready && !s_r.rvalid) begin
			s_nxt.arready = 1'b1;
			s_nxt.rvalid  = 1'b1;
			s_nxt.rresp   = pts_pkg::RESP_OKAY;
			s_nxt.rdata   = 32'h0000_0000;
			unique case (s_axi_araddr[7:0])
				pts_pkg::CTRL_OFF:     s_nxt.rdata[7:0] = s_r.ctrl; // RL11
				pts_pkg::PERIOD_OFF:   s_nxt.rdata[7:0] = s_r.period;
				pts_pkg::COUNT_OFF:    s_nxt.rdata[7:0] = s_r.count;
				pts_pkg::IRQ_FLAG_OFF: s_nxt.rdata[0]   = s_r.flag;
				pts_pkg::IRQ_EN_OFF:   s_nxt.rdata[0]   = s_r.enable;
				pts_pkg::AUX_OFF:      s_nxt.rdata[0]   = s_r.spi_sel;
				default:               s_nxt.rresp      = pts_pkg::RESP_SLVERR;
			endcase
		end else if (s_r.rvalid && s_axi_rready) begin
			s_nxt.rvalid = 1'b0;
		end
		// ready flags kept in flops so the bus sees registered outputs
		s_nxt.awready = !s_nxt.aw_got;
		s_nxt.wready  = !s_nxt.w_got;
		// registered outputs
		s_nxt.irq = s_nxt.flag && s_nxt.enable; // RL3
		s_nxt.pwm = match; // RL5
		s_nxt.spi = match && s_r.spi_sel; // RL6
	end

	// reset clears count, sets period to ones, control to zero
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_r        <= '0;
			s_r.ctrl   <= pts_pkg::CTRL_RST; // RL16
			s_r.period <= pts_pkg::PERIOD_RST; // RL15
			s_r.count  <= pts_pkg::COUNT_RST; // RL15
			s_r.awready <= 1'b1;
			s_r.wready  <= 1'b1;
		end else begin
			s_r <= s_nxt; // RL8
		end
	end

	assign s_axi_awready = s_r.awready;
	assign s_axi_wready  = s_r.wready;
	assign s_axi_bvalid  = s_r.bvalid;
	assign s_axi_bresp   = s_r.bresp;
	assign s_axi_arready = s_r.arready;
	assign s_axi_rvalid  = s_r.rvalid;
	assign s_axi_rdata   = s_r.rdata;
	assign s_axi_rresp   = s_r.rresp;
	assign irq           = s_r.irq;
	assign pwm_time_base = s_r.pwm;
	assign spi_shift_clk = s_r.spi;
endmodule : pts_timer

// >>> test/pts_far_model.sv
`timescale 1ns/1ps
// pwm unit and serial port stand-in: counts the pulses it is offered
module pts_far_model (
	input wire logic aclk,
	input wire logic pwm_time_base,
	input wire logic spi_shift_clk
);
	int n_pwm = 0;
	int n_spi = 0;
	// one count per high cycle
	always @(posedge aclk) begin
		n_pwm <= n_pwm + int'(pwm_time_base);
		n_spi <= n_spi + int'(spi_shift_clk);
	end
endmodule : pts_far_model

// >>> test/pts_timer_monitor.sv
`timescale 1ns/1ps
// port-level timing checks on the timer
module pts_timer_monitor (
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        sleep,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic        irq,
	input wire logic        pwm_time_base,
	input wire logic        spi_shift_clk
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// pulses sit at least one instruction tick apart
	property p_gap; pwm_time_base |=> !pwm_time_base [*3]; endproperty
	a_gap: assert property (p_gap) else $error("pulses too close");
	property p_slp; $past(sleep, 2) && $past(sleep) && sleep |-> !pwm_time_base; endproperty
	a_slp: assert property (p_slp) else $error("pulse in sleep");
	property p_spi; spi_shift_clk |-> pwm_time_base; endproperty
	a_spi: assert property (p_spi) else $error("stray shift clock");
	property p_rst; $rose(aresetn) |-> !irq && !pwm_time_base && !s_axi_bvalid && s_axi_awready; endproperty
	a_rst: assert property (p_rst) else $error("bad reset state");
	property p_bh; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
	a_bh: assert property (p_bh) else $error("bvalid dropped");
	property p_rh; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
	a_rh: assert property (p_rh) else $error("read data dropped");
	property p_rd; s_axi_arvalid && !s_axi_arready && !s_axi_rvalid |=> s_axi_arready && s_axi_rvalid; endproperty
	a_rd: assert property (p_rd) else $error("late read answer");
	property p_wr; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid; endproperty
	a_wr: assert property (p_wr) else $error("late write answer");
	c_irq: cover property (irq);
	c_spi: cover property (spi_shift_clk);
	c_slp: cover property (sleep [*3]);
endmodule : pts_timer_monitor
bind pts_timer pts_timer_monitor u_mon (.*);

// >>> test/pts_timer_test.sv
`timescale 1ns/1ps
// drives the timer over its register bus and checks pulses and interrupt
module pts_timer_test;
	logic        aclk = 0;
	logic        aresetn = 0;
	logic        sleep = 0;
	logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0;
	logic [3:0]  s_axi_wstrb = 4'hf;
	logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	logic        irq, pwm_time_base, spi_shift_clk;
	int          err_total = 0;
	int          comparisons = 0;
	int          n0, s0, c;
	pts_timer u_dut (.*);
	pts_far_model u_far (.aclk, .pwm_time_base, .spi_shift_clk);
	initial forever #20 aclk = ~aclk;
	task conclude;
		$display("errors %0d comparisons %0d", err_total, comparisons);
		if (err_total == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : conclude
	task chk(input logic [31:0] g, input logic [31:0] e);
		comparisons++;
		if (g !== e) begin
			$display("ERROR %0t got %h exp %h", $time, g, e);
			err_total++;
		end
	endtask : chk
	// a used-up wait ends the run
	task tmo(input int n);
		if (n >= 3000) begin
			$display("ERROR %0t timeout", $time);
			err_total++;
			conclude();
		end
	endtask : tmo
	task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = pts_pkg::RESP_OKAY);
		int n;
		@(posedge aclk);
		s_axi_awaddr <= {24'h000000, a};
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (n = 0; n < 3000; n++) begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) break;
		end
		s_axi_bready <= 1'b0;
		tmo(n);
		chk({30'h0, s_axi_bresp}, {30'h0, r});
	endtask : wr
	task rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r = pts_pkg::RESP_OKAY);
		int n;
		@(posedge aclk);
		s_axi_araddr <= {24'h000000, a};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (n = 0; n < 3000; n++) begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) break;
		end
		s_axi_rready <= 1'b0;
		tmo(n);
		chk(s_axi_rdata, e);
		chk({30'h0, s_axi_rresp}, {30'h0, r});
	endtask : rd
	// waits for the interrupt or a match pulse, c counts the edges
	task wt(input bit on_irq);
		for (c = 1; c < 3000; c++) begin
			@(posedge aclk);
			if (on_irq ? irq : pwm_time_base) break;
		end
		tmo(c);
	endtask : wt
	initial begin
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		rd(pts_pkg::CTRL_OFF, 32'h0);
		rd(pts_pkg::PERIOD_OFF, 32'hff);
		rd(pts_pkg::COUNT_OFF, 32'h0);
		rd(8'h18, 32'h0, pts_pkg::RESP_SLVERR);
		wr(8'h18, 32'h1, pts_pkg::RESP_SLVERR);
		wr(pts_pkg::CTRL_OFF, 32'hff);
		rd(pts_pkg::CTRL_OFF, 32'h7f);
		wr(pts_pkg::CTRL_OFF, 32'h0);
		wr(pts_pkg::COUNT_OFF, 32'h0);
		wr(pts_pkg::PERIOD_OFF, 32'h1);
		// pulse spacing is 4 clocks times prescale times period plus one
		for (int s = 0; s < 4; s++) begin
			wr(pts_pkg::CTRL_OFF, 32'(4 + s));
			wt(0);
			wt(0);
			chk(32'(c), 32'(8 << (2 * s)));
		end
		chk(32'(u_far.n_spi), 32'h0);
		wr(pts_pkg::PERIOD_OFF, 32'h0);
		wr(pts_pkg::IRQ_EN_OFF, 32'h1);
		wr(pts_pkg::AUX_OFF, 32'h1);
		// smallest and largest postscale
		for (int p = 0; p < 16; p += 15) begin
			wr(pts_pkg::CTRL_OFF, 32'h0);
			wr(pts_pkg::COUNT_OFF, 32'h0);
			wr(pts_pkg::IRQ_FLAG_OFF, 32'h1);
			n0 = u_far.n_pwm;
			s0 = u_far.n_spi;
			wr(pts_pkg::CTRL_OFF, 32'(p * 8 + 4));
			wt(1);
			// let the far model count the pulse that came with the flag
			@(posedge aclk);
			chk(32'(u_far.n_pwm - n0), 32'(p + 1));
			chk(32'(u_far.n_spi - s0), 32'(p + 1));
		end
		wr(pts_pkg::CTRL_OFF, 32'h0);
		wr(pts_pkg::IRQ_EN_OFF, 32'h0);
		n0 = u_far.n_pwm;
		rd(pts_pkg::IRQ_FLAG_OFF, 32'h1);
		chk({31'h0, irq}, 32'h0);
		wr(pts_pkg::IRQ_EN_OFF, 32'h1);
		rd(pts_pkg::IRQ_FLAG_OFF, 32'h1);
		chk({31'h0, irq}, 32'h1);
		wr(pts_pkg::IRQ_FLAG_OFF, 32'h1);
		rd(pts_pkg::IRQ_FLAG_OFF, 32'h0);
		chk({31'h0, irq}, 32'h0);
		chk(32'(u_far.n_pwm - n0), 32'h0);
		// asleep: a running timer keeps its count and period
		sleep <= 1'b1;
		wr(pts_pkg::COUNT_OFF, 32'h5);
		n0 = u_far.n_pwm;
		wr(pts_pkg::CTRL_OFF, 32'h4);
		repeat (100) @(posedge aclk);
		rd(pts_pkg::COUNT_OFF, 32'h5);
		rd(pts_pkg::PERIOD_OFF, 32'h0);
		chk(32'(u_far.n_pwm - n0), 32'h0);
		sleep <= 1'b0;
		// awake again: counting resumes at the programmed rate
		wt(0);
		wt(0);
		chk(32'(c), 32'h4);
		conclude();
	end
endmodule : pts_timer_test
